// [tb.sv]
// self-checking bench for the waveform setting validator
`timescale 1ns/1ps
`include "wsv_params.svh"
module tb;
    typedef struct packed {
        logic [2:0] op;
        logic [1:0] kw;
        logic [19:0] wave;
        logic [47:0] freq, e_freq;
        logic [15:0] amp, e_amp;
        logic [7:0] duty, e_duty;
        logic [9:0] mode;
        logic [2:0] e_wave, e_mode;
        logic [1:0] e_ist;
    } wsv_row_t;
    localparam logic [47:0] F1K = `WSV_F_1K;
    localparam logic [47:0] F1M = 48'h00E8D4A51000;
    localparam logic [47:0] F8M = 48'h0746A5288000;
    localparam logic [47:0] F100K = `WSV_F_100K;
    localparam logic [47:0] F15M = `WSV_F_15M;
    localparam logic [47:0] F2M5 = `WSV_F_2M5;
    localparam logic [15:0] A100 = `WSV_AMP_DEF;
    localparam logic [15:0] AMX = `WSV_AMP_MAX;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0] syn_wave, syn_arb, syn_mode, syn_modwave;
    logic [13:0] syn_points;
    logic [47:0] syn_freq;
    logic [15:0] syn_amp, syn_offset;
    logic [7:0] syn_duty;
    logic [1:0] syn_trig_src;
    logic syn_sweep_log, syn_trig_slope, syn_update, err_led, irq, er;
    int num_errors = 0;
    int samples_checked = 0;
    int upd_seen = 0;
    wsv_row_t rows [17];

    wsv_host i_wsv_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    wsv_waveform_setting_validator i_wsv_waveform_setting_validator (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .syn_wave(syn_wave), .syn_arb(syn_arb), .syn_points(syn_points), .syn_freq(syn_freq),
        .syn_amp(syn_amp), .syn_offset(syn_offset), .syn_duty(syn_duty), .syn_mode(syn_mode),
        .syn_modwave(syn_modwave), .syn_sweep_log(syn_sweep_log), .syn_trig_src(syn_trig_src),
        .syn_trig_slope(syn_trig_slope), .syn_update(syn_update), .err_led(err_led),
        .irq(irq));

    always @(posedge pclk) if (syn_update === 1'h1) upd_seen++;

    initial pclk = 1'h0;
    always #50 pclk = ~pclk;

    task give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : give_verdict

    task chk(input logic [47:0] got, input logic [47:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk

    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        logic ok;
        i_wsv_host.xfer(w, a, d, rd, er, ok);
        if (!ok) begin
            num_errors++;
            give_verdict();
        end
    endtask : bus

    // outputs are looked at on the falling edge, well clear of the launching edge
    task settle;
        repeat (2) @(negedge pclk);
    endtask : settle

    task wait_idle;
        int n;
        rd = 32'h00000008;
        for (n = 0; n < 20 && rd[3] !== 1'h0; n++) bus(1'h0, `WSV_A_STATUS, 32'h0);
        if (rd[3] !== 1'h0) begin
            num_errors++;
            give_verdict();
        end
    endtask : wait_idle

    task run(input wsv_row_t r);
        bus(1'h1, `WSV_A_WAVE, {12'h000, r.wave});
        bus(1'h1, `WSV_A_FLO, r.freq[31:0]);
        bus(1'h1, `WSV_A_FHI, {16'h0000, r.freq[47:32]});
        bus(1'h1, `WSV_A_LEVEL, {16'h0000, r.amp});
        bus(1'h1, `WSV_A_DUTY, {24'h000000, r.duty});
        bus(1'h1, `WSV_A_MOD, {22'h000000, r.mode});
        bus(1'h1, `WSV_A_CMD, {27'h0000000, r.kw, r.op});
        wait_idle();
        settle();
    endtask : run

    initial begin
        presetn = 1'h0;
        rows = '{
            '{3'h6, 2'h0, 20'h00200, F1K, F1K, A100, A100, 8'h32, 8'h32, 10'h000, 3'h0, 3'h0, 2'h0},
            '{3'h5, 2'h0, 20'h00200, F1K, F1K, A100, A100, 8'h32, 8'h32, 10'h021, 3'h0, 3'h1, 2'h0},
            '{3'h1, 2'h0, 20'h00204, F1K, F1K, A100, A100, 8'h32, 8'h32, 10'h021, 3'h4, 3'h0, 2'h0},
            '{3'h1, 2'h0, 20'h00200, F1K, F1K, A100, A100, 8'h32, 8'h32, 10'h000, 3'h0, 3'h0, 2'h0},
            '{3'h2, 2'h0, 20'h00200, F1M, F1M, A100, A100, 8'h32, 8'h32, 10'h000, 3'h0, 3'h0, 2'h0},
            '{3'h1, 2'h0, 20'h00202, F1K, F100K, A100, A100, 8'h32, 8'h32, 10'h0, 3'h2, 3'h0, 2'h1},
            '{3'h1, 2'h0, 20'h00201, F1K, F100K, A100, A100, 8'h32, 8'h32, 10'h0, 3'h1, 3'h0, 2'h0},
            '{3'h4, 2'h0, 20'h00201, F1K, F100K, A100, A100, 8'h46, 8'h46, 10'h0, 3'h1, 3'h0, 2'h0},
            '{3'h2, 2'h0, 20'h00201, F8M, F8M, A100, A100, 8'h46, 8'h3C, 10'h000, 3'h1, 3'h0, 2'h1},
            '{3'h2, 2'h1, 20'h00201, F1K, `WSV_F_MIN, A100, A100, 8'h46, 8'h3C, 10'h0, 3'h1, 3'h0, 2'h0},
            '{3'h2, 2'h2, 20'h00201, F1K, F15M, A100, A100, 8'h46, 8'h3C, 10'h0, 3'h1, 3'h0, 2'h0},
            '{3'h1, 2'h0, 20'hBFFED, F1K, F2M5, A100, A100, 8'h46, 8'h3C, 10'h0, 3'h5, 3'h0, 2'h1},
            '{3'h5, 2'h0, 20'hBFFED, F1K, F2M5, A100, A100, 8'h46, 8'h3C, 10'h5, 3'h5, 3'h5, 2'h0},
            '{3'h1, 2'h0, 20'h00204, F1K, F2M5, A100, A100, 8'h46, 8'h3C, 10'h5, 3'h4, 3'h0, 2'h0},
            '{3'h3, 2'h0, 20'h00204, F1K, F2M5, 16'h4E20, AMX, 8'h46, 8'h3C, 10'h0, 3'h4, 3'h0, 2'h1},
            '{3'h1, 2'h0, 20'h00207, F1K, F2M5, A100, AMX, 8'h46, 8'h3C, 10'h0, 3'h4, 3'h0, 2'h2},
            '{3'h6, 2'h0, 20'h00201, F1K, F1K, A100, A100, 8'h46, 8'h32, 10'h021, 3'h1, 3'h0, 2'h0}
        };
        repeat (3) @(posedge pclk);
        presetn <= 1'h1;
        // first row is the combined apply, ahead of any other configuration
        for (int i = 0; i < 17; i++) begin
            run(rows[i]);
            chk(syn_wave, rows[i].e_wave);
            chk(syn_freq, rows[i].e_freq);
            chk(syn_amp, rows[i].e_amp);
            chk(syn_duty, rows[i].e_duty);
            chk(syn_mode, rows[i].e_mode);
            bus(1'h0, `WSV_A_ISTAT, 32'h0);
            chk(rd[1:0], rows[i].e_ist);
            bus(1'h1, `WSV_A_ISTAT, 32'h0000000F);
            $display("row %0d done", i);
        end
        settle();
        chk(upd_seen, 16);
        chk(irq, 1'h0);
        bus(1'h1, `WSV_A_IMASK, 32'h00000001);
        run(rows[14]);
        chk(irq, 1'h1);
        bus(1'h1, `WSV_A_IMASK, 32'h00000000);
        settle();
        chk(irq, 1'h0);
        bus(1'h1, `WSV_A_IMASK, 32'h00000001);
        settle();
        chk(irq, 1'h1);
        bus(1'h1, `WSV_A_ISTAT, 32'h00000001);
        settle();
        chk(irq, 1'h0);
        $display("interrupt test done");
        chk(err_led, 1'h1);
        bus(1'h0, `WSV_A_ERRQ, 32'h0);
        chk(rd, 32'hFFFFFF23);
        for (int n = 0; n < 8 && rd !== 32'h0; n++) bus(1'h0, `WSV_A_ERRQ, 32'h0);
        settle();
        chk(err_led, 1'h0);
        $display("error queue test done");
        bus(1'h0, 8'h3C, 32'h0);
        chk(er, 1'h1);
        bus(1'h1, `WSV_A_STATUS, 32'h0);
        chk(er, 1'h1);
        bus(1'h1, `WSV_A_CMD, {27'h0000000, 2'h0, 3'h2});
        bus(1'h0, `WSV_A_STATUS, 32'h0);
        bus(1'h1, `WSV_A_CMD, {27'h0000000, 2'h0, 3'h2});
        chk(er, 1'h1);
        wait_idle();
        $display("refusal test done");
        // a second reset from a non-default state must restore every default
        @(posedge pclk);
        presetn <= 1'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'h1;
        settle();
        chk(syn_wave, 3'h0);
        chk(syn_freq, F1K);
        chk(syn_amp, A100);
        chk({syn_offset, syn_duty, syn_arb, syn_points}, {16'h0000, 8'h32, 3'h0, 14'h0008});
        chk({syn_update, syn_mode, syn_modwave, syn_sweep_log, syn_trig_src, syn_trig_slope}, 11'h000);
        chk(err_led, 1'h0);
        bus(1'h0, `WSV_A_ACT_FLO, 32'h0);
        chk(rd, 32'h3B9ACA00);
        bus(1'h0, `WSV_A_ACT_WAVE, 32'h0);
        chk(rd, 32'h00000200);
        $display("reset test done");
        give_verdict();
    end
endmodule : tb

// [wsv_host.sv]
// apb host model that issues configuration transfers to the validator
`timescale 1ns/1ps
module wsv_host (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
    end

    // released lines are flipped so that a stale value never passes for a live one
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] rd, output logic er, output logic ok);
        int n;
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        ok = 1'h0;
        for (n = 0; n < 16 && !ok; n++) begin
            @(posedge pclk);
            ok = (pready === 1'h1);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        pwrite <= ~w;
        paddr <= ~a;
        pwdata <= ~d;
    endtask : xfer
endmodule : wsv_host

// [wsv_params.svh]
// constants for the waveform setting validator
`ifndef WSV_PARAMS_SVH
`define WSV_PARAMS_SVH
`define WSV_A_CMD 8'h00
`define WSV_A_WAVE 8'h04
`define WSV_A_FLO 8'h08
`define WSV_A_FHI 8'h0C
`define WSV_A_LEVEL 8'h10
`define WSV_A_DUTY 8'h14
`define WSV_A_MOD 8'h18
`define WSV_A_STATUS 8'h1C
`define WSV_A_ERRQ 8'h20
`define WSV_A_ISTAT 8'h24
`define WSV_A_IMASK 8'h28
`define WSV_A_ACT_WAVE 8'h44
`define WSV_A_ACT_FLO 8'h48
`define WSV_A_ACT_FHI 8'h4C
`define WSV_A_ACT_LEVEL 8'h50
`define WSV_A_ACT_DUTY 8'h54
`define WSV_A_ACT_MOD 8'h58
`define WSV_OP_FUNC 3'h1
`define WSV_OP_FREQ 3'h2
`define WSV_OP_VOLT 3'h3
`define WSV_OP_DUTY 3'h4
`define WSV_OP_MOD 3'h5
`define WSV_OP_APPLY 3'h6
`define WSV_KW_VAL 2'h0
`define WSV_KW_MIN 2'h1
`define WSV_KW_MAX 2'h2
`define WSV_WAVE_LAST 3'h6
`define WSV_MODE_LAST 3'h5
`define WSV_ARB_CUSTOM 3'h5
`define WSV_F_15M 48'h0DA475ABF000
`define WSV_F_5M 48'h048C27395000
`define WSV_F_2M5 48'h0246139CA800
`define WSV_F_200K 48'h002E90EDD000
`define WSV_F_100K 48'h00174876E800
`define WSV_F_1K 48'h00003B9ACA00
`define WSV_F_MIN 48'h000000000064
`define WSV_F_MIN_USER 48'h0000000186A0
`define WSV_PTS_8K 14'h2000
`define WSV_PTS_12K 14'h2FFF
`define WSV_AMP_MAX 16'h2710
`define WSV_AMP_DEF 16'h0064
`define WSV_OFF_DEF 16'h0000
`define WSV_PTS_DEF 14'h0008
`define WSV_DUTY_DEF 8'h32
`define WSV_DUTY_LO 8'h14
`define WSV_DUTY_HI 8'h50
`define WSV_DUTY_NLO 8'h28
`define WSV_DUTY_NHI 8'h3C
`define WSV_TSRC_DEF 2'h0
`define WSV_TSLOPE_DEF 1'b0
`define WSV_E_CONFLICT 16'hFF23
`define WSV_E_ILLEGAL 16'hFF20
`define WSV_ERRQ_DEPTH 4
`define WSV_ECNT_W 3
`endif

// [wsv_pkg.sv]
// types of the waveform setting validator
`include "wsv_params.svh"
package wsv_pkg;
    typedef enum logic [2:0] {WSV_SINE, WSV_SQUARE, WSV_TRIANGLE, WSV_RAMP, WSV_NOISE,
        WSV_USER, WSV_DC} wsv_wave_t;
    typedef enum logic [2:0] {WSV_M_NONE, WSV_M_AM, WSV_M_FM, WSV_M_FSK, WSV_M_BURST,
        WSV_M_SWEEP} wsv_mode_t;
    typedef enum logic [2:0] {WSV_IDLE, WSV_LOAD, WSV_WAVE, WSV_FREQ, WSV_DUTY,
        WSV_COMMIT} wsv_fsm_t;
    typedef struct packed {
        logic [13:0] pts;
        logic [2:0] arb;
        wsv_wave_t wave;
        logic [47:0] freq;
        logic [15:0] off;
        logic [15:0] amp;
        logic [7:0] duty;
        logic tslope;
        logic [1:0] tsrc;
        logic sweep_log;
        wsv_wave_t modwave;
        wsv_mode_t mode;
    } wsv_cfg_t;
    typedef struct packed {
        logic [19:0] s_wave;
        logic [47:0] s_freq;
        logic [31:0] s_level;
        logic [7:0] s_duty;
        logic [9:0] s_mod;
        logic [2:0] op;
        logic [1:0] kw;
        logic conf;
        logic ill;
        logic moff;
        wsv_fsm_t fsm;
        wsv_cfg_t w;
        wsv_cfg_t a;
        logic [`WSV_ERRQ_DEPTH-1:0][15:0] errq;
        logic [`WSV_ECNT_W-1:0] ecnt;
        logic [3:0] istat;
        logic [3:0] imask;
        logic upd;
        logic [31:0] prdata;
        logic slverr;
    } wsv_state_t;
endpackage : wsv_pkg

// [wsv_waveform_setting_validator.sv]
// waveform setting validator: apb registers, clamping sequencer, error queue
// Function
// - offer sine, square, triangle, ramp, noise, user arbitrary and dc outputs
// - arbitrary source is one of five built-in shapes or the custom download
// - waveform is sine after reset
// - noise only as am/fm modulating wave, never carrier, fsk, burst, sweep (code accepts noise as modulating wave for every mode)
// - selecting a waveform the active mode forbids turns the mode off
// - sweep, linear or log, allowed for every waveform except noise
// - minimum 100 uHz; maximum 15 MHz, 5 MHz built-in arb, 100 kHz ramp/tri
// - frequency is 1 kHz after reset
// - custom arb maximum from point count: 5M, 2.5M, 200k; minimum 100 mHz
// - waveform change lowering maximum clamps frequency and raises -221
// - amplitude above the waveform maximum is clamped and raises -221
// - square duty 40..60 above 5 MHz, otherwise 20..80
// - frequency making duty invalid clamps duty to nearest limit, raises -221
// - apply sets shape, frequency, level; resets duty, modulation, trigger
// - waveform command accepts exactly the seven choices
// - frequency keywords min and max resolve to the current waveform limits
// - amplitude is 100 mVpp after reset
// - error indicator on while the error queue holds an entry
//
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "wsv_params.svh"
module wsv_waveform_setting_validator (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [2:0] syn_wave,
    output logic [2:0] syn_arb,
    output logic [13:0] syn_points,
    output logic [47:0] syn_freq,
    output logic [15:0] syn_amp,
    output logic [15:0] syn_offset,
    output logic [7:0] syn_duty,
    output logic [2:0] syn_mode,
    output logic [2:0] syn_modwave,
    output logic syn_sweep_log,
    output logic [1:0] syn_trig_src,
    output logic syn_trig_slope,
    output logic syn_update,
    output logic err_led,
    output logic irq
);
    wsv_pkg::wsv_state_t q;
    wsv_pkg::wsv_state_t d;
    logic acc_wr;
    logic acc_rd;
    logic pop;
    logic push;
    logic busy;
    logic hit;
    logic ro;
    logic [15:0] code;
    logic [31:0] rdat;
    logic [47:0] fhi;
    logic [47:0] flo;
    logic [7:0] dlo;
    logic [7:0] dhi;
    logic [`WSV_ECNT_W-1:0] cnt;

    function automatic logic [47:0] fmax(input wsv_pkg::wsv_cfg_t c);
        logic [47:0] f;
        f = `WSV_F_15M;
        if (c.wave == wsv_pkg::WSV_TRIANGLE || c.wave == wsv_pkg::WSV_RAMP) begin
            f = `WSV_F_100K;
        end else if (c.wave == wsv_pkg::WSV_USER) begin
            if (c.arb != `WSV_ARB_CUSTOM) begin
                f = `WSV_F_5M;
            end else if (c.pts <= `WSV_PTS_8K) begin
                f = `WSV_F_5M;
            end else if (c.pts <= `WSV_PTS_12K) begin
                f = `WSV_F_2M5;
            end else begin
                f = `WSV_F_200K;
            end
        end
        return f;
    endfunction : fmax

    function automatic logic [47:0] fmin(input wsv_pkg::wsv_cfg_t c);
        logic [47:0] f;
        f = `WSV_F_MIN;
        if (c.wave == wsv_pkg::WSV_USER && c.arb == `WSV_ARB_CUSTOM) begin
            f = `WSV_F_MIN_USER;
        end
        return f;
    endfunction : fmin

    assign busy = (q.fsm != wsv_pkg::WSV_IDLE);
    assign acc_wr = psel & penable & pwrite & ~q.slverr;
    assign acc_rd = psel & penable & ~pwrite & ~q.slverr;

    always_comb begin
        rdat = '0;
        hit = 1'b1;
        ro = 1'b0;
        if (paddr == `WSV_A_CMD) begin
            rdat = '0;
        end else if (paddr == `WSV_A_WAVE) begin
            rdat = 32'(q.s_wave);
        end else if (paddr == `WSV_A_FLO) begin
            rdat = q.s_freq[31:0];
        end else if (paddr == `WSV_A_FHI) begin
            rdat = 32'(q.s_freq[47:32]);
        end else if (paddr == `WSV_A_LEVEL) begin
            rdat = q.s_level;
        end else if (paddr == `WSV_A_DUTY) begin
            rdat = 32'(q.s_duty);
        end else if (paddr == `WSV_A_MOD) begin
            rdat = 32'(q.s_mod);
        end else if (paddr == `WSV_A_STATUS) begin
            rdat = 32'({q.ecnt != '0, busy, q.ecnt});
            ro = 1'b1;
        end else if (paddr == `WSV_A_ERRQ) begin
            rdat = (q.ecnt != '0) ? 32'(signed'(q.errq[0])) : '0;
            ro = 1'b1;
        end else if (paddr == `WSV_A_ISTAT) begin
            rdat = 32'(q.istat);
        end else if (paddr == `WSV_A_IMASK) begin
            rdat = 32'(q.imask);
        end else if (paddr == `WSV_A_ACT_WAVE) begin
            rdat = 32'({q.a.pts, q.a.arb, q.a.wave});
            ro = 1'b1;
        end else if (paddr == `WSV_A_ACT_FLO) begin
            rdat = q.a.freq[31:0];
            ro = 1'b1;
        end else if (paddr == `WSV_A_ACT_FHI) begin
            rdat = 32'(q.a.freq[47:32]);
            ro = 1'b1;
        end else if (paddr == `WSV_A_ACT_LEVEL) begin
            rdat = {q.a.off, q.a.amp};
            ro = 1'b1;
        end else if (paddr == `WSV_A_ACT_DUTY) begin
            rdat = 32'(q.a.duty);
            ro = 1'b1;
        end else if (paddr == `WSV_A_ACT_MOD) begin
            rdat = 32'({q.a.tslope, q.a.tsrc, q.a.sweep_log, q.a.modwave, q.a.mode});
            ro = 1'b1;
        end else begin
            hit = 1'b0;
        end
    end

    always_comb begin
        d = q;
        d.upd = 1'b0;
        push = 1'b0;
        code = '0;
        fhi = fmax(q.w);
        flo = fmin(q.w);
        dlo = (q.w.freq > `WSV_F_5M) ? `WSV_DUTY_NLO : `WSV_DUTY_LO;
        dhi = (q.w.freq > `WSV_F_5M) ? `WSV_DUTY_NHI : `WSV_DUTY_HI;
        // read data and error answer are fixed in the setup cycle
        if (psel && !penable) begin
            d.prdata = pwrite ? '0 : rdat;
            d.slverr = !hit || (pwrite && ro) || (pwrite && busy && paddr == `WSV_A_CMD);
        end
        if (acc_wr) begin
            if (paddr == `WSV_A_CMD) begin
                {d.kw, d.op} = 5'(pwdata);
                d.fsm = wsv_pkg::WSV_LOAD;
            end else if (paddr == `WSV_A_WAVE) begin
                d.s_wave = 20'(pwdata);
            end else if (paddr == `WSV_A_FLO) begin
                d.s_freq[31:0] = pwdata;
            end else if (paddr == `WSV_A_FHI) begin
                d.s_freq[47:32] = 16'(pwdata);
            end else if (paddr == `WSV_A_LEVEL) begin
                d.s_level = pwdata;
            end else if (paddr == `WSV_A_DUTY) begin
                d.s_duty = 8'(pwdata);
            end else if (paddr == `WSV_A_MOD) begin
                d.s_mod = 10'(pwdata);
            end else if (paddr == `WSV_A_IMASK) begin
                d.imask = 4'(pwdata);
            end
        end
        case (q.fsm)
            wsv_pkg::WSV_LOAD: begin
                d.w = q.a;
                d.conf = 1'b0;
                d.ill = 1'b0;
                d.moff = 1'b0;
                d.fsm = wsv_pkg::WSV_WAVE;
                if (q.op != `WSV_OP_FREQ && q.op != `WSV_OP_APPLY) begin
                    d.kw = `WSV_KW_VAL;
                end
                case (q.op)
                    `WSV_OP_FUNC, `WSV_OP_APPLY: begin
                        // only seven shapes and six arbitrary sources exist
                        if (q.s_wave[2:0] > `WSV_WAVE_LAST
                            || q.s_wave[5:3] > `WSV_ARB_CUSTOM) begin
                            d.ill = 1'b1;
                        end else begin
                            {d.w.pts, d.w.arb} = q.s_wave[19:3];
                            d.w.wave = wsv_pkg::wsv_wave_t'(q.s_wave[2:0]);
                            if (q.op == `WSV_OP_APPLY) begin
                                d.w.freq = q.s_freq;
                                {d.w.off, d.w.amp} = q.s_level;
                                d.w.duty = `WSV_DUTY_DEF;
                                d.w.mode = wsv_pkg::WSV_M_NONE;
                                d.w.tsrc = `WSV_TSRC_DEF;
                                d.w.tslope = `WSV_TSLOPE_DEF;
                            end
                        end
                    end
                    `WSV_OP_FREQ: d.w.freq = q.s_freq;
                    `WSV_OP_VOLT: {d.w.off, d.w.amp} = q.s_level;
                    `WSV_OP_DUTY: d.w.duty = q.s_duty;
                    `WSV_OP_MOD: begin
                        if (q.s_mod[2:0] > `WSV_MODE_LAST || q.s_mod[5:3] > `WSV_WAVE_LAST) begin
                            d.ill = 1'b1;
                        end else begin
                            // noise stays a legal modulating shape for am and fm
                            {d.w.tslope, d.w.tsrc, d.w.sweep_log} = q.s_mod[9:6];
                            d.w.modwave = wsv_pkg::wsv_wave_t'(q.s_mod[5:3]);
                            d.w.mode = wsv_pkg::wsv_mode_t'(q.s_mod[2:0]);
                        end
                    end
                    default: d.ill = 1'b1;
                endcase
                if (d.ill) begin
                    d.fsm = wsv_pkg::WSV_COMMIT;
                end
            end
            wsv_pkg::WSV_WAVE: begin
                if (q.w.wave == wsv_pkg::WSV_NOISE && q.w.mode != wsv_pkg::WSV_M_NONE) begin
                    d.w.mode = wsv_pkg::WSV_M_NONE;
                    d.moff = 1'b1;
                end
                if (q.w.amp > `WSV_AMP_MAX) begin
                    d.w.amp = `WSV_AMP_MAX;
                    d.conf = 1'b1;
                end
                d.fsm = wsv_pkg::WSV_FREQ;
            end
            wsv_pkg::WSV_FREQ: begin
                if (q.kw == `WSV_KW_MIN) begin
                    d.w.freq = flo;
                end else if (q.kw == `WSV_KW_MAX) begin
                    d.w.freq = fhi;
                end else if (q.w.freq > fhi) begin
                    d.w.freq = fhi;
                    d.conf = 1'b1;
                end else if (q.w.freq < flo) begin
                    d.w.freq = flo;
                    d.conf = 1'b1;
                end
                d.fsm = wsv_pkg::WSV_DUTY;
            end
            wsv_pkg::WSV_DUTY: begin
                if (q.w.wave == wsv_pkg::WSV_SQUARE && q.w.duty < dlo) begin
                    d.w.duty = dlo;
                    d.conf = 1'b1;
                end else if (q.w.wave == wsv_pkg::WSV_SQUARE && q.w.duty > dhi) begin
                    d.w.duty = dhi;
                    d.conf = 1'b1;
                end
                d.fsm = wsv_pkg::WSV_COMMIT;
            end
            wsv_pkg::WSV_COMMIT: begin
                // the synthesis ports change only here, after every clamp
                if (!q.ill) begin
                    d.a = q.w;
                    d.upd = 1'b1;
                end
                push = q.ill || q.conf;
                code = q.ill ? `WSV_E_ILLEGAL : `WSV_E_CONFLICT;
                d.fsm = wsv_pkg::WSV_IDLE;
            end
            // a command write has already chosen the next state
            wsv_pkg::WSV_IDLE: ;
            default: d.fsm = wsv_pkg::WSV_IDLE;
        endcase
        // interrupt flags: a new event wins over a write-one clear
        d.istat = q.istat;
        if (acc_wr && paddr == `WSV_A_ISTAT) begin
            d.istat = q.istat & ~4'(pwdata);
        end
        if (q.fsm == wsv_pkg::WSV_COMMIT) begin
            d.istat = d.istat | {1'b1, q.moff & ~q.ill, q.ill, q.conf & ~q.ill};
        end
        // error queue: reading the head pops it; when full a new entry is lost
        cnt = q.ecnt;
        if (pop) begin
            for (int i = 0; i < `WSV_ERRQ_DEPTH - 1; i++) begin
                d.errq[i] = q.errq[i + 1];
            end
            cnt = q.ecnt - 1'b1;
        end
        if (push && cnt < `WSV_ECNT_W'(`WSV_ERRQ_DEPTH)) begin
            d.errq[cnt] = code;
            cnt = cnt + 1'b1;
        end
        d.ecnt = cnt;
    end

    assign pop = acc_rd && paddr == `WSV_A_ERRQ && q.ecnt != '0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
            q.s_wave <= 20'({`WSV_PTS_DEF, 3'h0, 3'h0});
            q.s_freq <= `WSV_F_1K;
            q.s_level <= {`WSV_OFF_DEF, `WSV_AMP_DEF};
            q.s_duty <= `WSV_DUTY_DEF;
            q.w <= '0;
            q.a.wave <= wsv_pkg::WSV_SINE;
            q.a.pts <= `WSV_PTS_DEF;
            q.a.freq <= `WSV_F_1K;
            q.a.amp <= `WSV_AMP_DEF;
            q.a.off <= `WSV_OFF_DEF;
            q.a.duty <= `WSV_DUTY_DEF;
            q.fsm <= wsv_pkg::WSV_IDLE;
        end else begin
            q <= d;
        end
    end

    assign prdata = q.prdata;
    assign pready = 1'b1;
    assign pslverr = q.slverr;
    assign syn_wave = q.a.wave;
    assign syn_arb = q.a.arb;
    assign syn_points = q.a.pts;
    assign syn_freq = q.a.freq;
    assign syn_amp = q.a.amp;
    assign syn_offset = q.a.off;
    assign syn_duty = q.a.duty;
    assign syn_mode = q.a.mode;
    assign syn_modwave = q.a.modwave;
    assign syn_sweep_log = q.a.sweep_log;
    assign syn_trig_src = q.a.tsrc;
    assign syn_trig_slope = q.a.tslope;
    assign syn_update = q.upd;
    assign err_led = (q.ecnt != '0);
    assign irq = |(q.istat & q.imask);

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_cmd;
        psel && penable && pwrite && !pslverr && paddr == `WSV_A_CMD;
    endsequence
    sequence s_run;
        busy[*2] ##[0:4] !busy;
    endsequence

    property p_commit_only;
        $changed(syn_freq) || $changed(syn_duty) |-> $past(q.fsm) == wsv_pkg::WSV_COMMIT;
    endproperty
    a_commit_only: assert property (p_commit_only) else $error("settings changed early");
    property p_cmd_done;
        s_cmd |=> s_run;
    endproperty
    a_cmd_done: assert property (p_cmd_done) else $error("command did not finish");
    property p_fmax;
        syn_freq <= fmax(q.a);
    endproperty
    a_fmax: assert property (p_fmax) else $error("frequency above limit");
    property p_fmin;
        syn_freq >= fmin(q.a);
    endproperty
    a_fmin: assert property (p_fmin) else $error("frequency below limit");
    property p_duty;
        syn_wave == wsv_pkg::WSV_SQUARE |-> (syn_freq > `WSV_F_5M)
            ? (syn_duty >= `WSV_DUTY_NLO && syn_duty <= `WSV_DUTY_NHI)
            : (syn_duty >= `WSV_DUTY_LO && syn_duty <= `WSV_DUTY_HI);
    endproperty
    a_duty: assert property (p_duty) else $error("square duty out of range");
    property p_noise;
        syn_wave == wsv_pkg::WSV_NOISE |-> syn_mode == wsv_pkg::WSV_M_NONE;
    endproperty
    a_noise: assert property (p_noise) else $error("noise carrier modulated");
    property p_err_led;
        q.fsm == wsv_pkg::WSV_COMMIT && q.conf && !pop && q.ecnt == '0 |=> err_led[*2];
    endproperty
    a_err_led: assert property (p_err_led) else $error("error indicator not on");
    property p_conflict;
        q.fsm == wsv_pkg::WSV_COMMIT && q.conf && !q.ill && !pop
            && q.ecnt < `WSV_ECNT_W'(`WSV_ERRQ_DEPTH) |=> q.ecnt == $past(q.ecnt) + 1'b1;
    endproperty
    a_conflict: assert property (p_conflict) else $error("conflict not queued");
    property p_apply;
        q.fsm == wsv_pkg::WSV_COMMIT && q.op == `WSV_OP_APPLY && !q.ill
            |=> syn_mode == wsv_pkg::WSV_M_NONE && syn_trig_src == `WSV_TSRC_DEF;
    endproperty
    a_apply: assert property (p_apply) else $error("apply left modulation on");
    property p_irq;
        q.fsm == wsv_pkg::WSV_COMMIT && q.conf && !q.ill && q.imask[0] |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not raised");
endmodule : wsv_waveform_setting_validator
